// ---- src/afp_cfg.svh ----
`ifndef AFP_CFG_SVH
`define AFP_CFG_SVH
// ----------------------------------------
// Timing and sizing constants
// ----------------------------------------
`define AFP_CLK_PERIOD_NS 8
`define AFP_HYST_NS 64
`define AFP_HYST_CYCLES ((`AFP_HYST_NS + `AFP_CLK_PERIOD_NS - 1) / `AFP_CLK_PERIOD_NS)
`define AFP_GAIN_WINDOW_CYCLES 1024
`define AFP_GAIN_EVENTS 4
`define AFP_GAIN_STEPS 7
`define AFP_GAIN_RST 3'h0
`define AFP_MODE_RST 2'h0
`define AFP_PROT_TIE 1'b1
`endif

// ---- src/afp_pkg.sv ----
package afp_pkg;
  typedef logic [1:0] afp_mode_type;
  typedef enum logic [2:0] {
    AFP_RESET = 3'b001,
    AFP_WAIT_SUPPLY = 3'b010,
    AFP_RUN = 3'b100
  } afp_state_type;
endpackage : afp_pkg

// ---- src/afp_monitor.sv ----
// Summary of operation
// R1 - Two-threshold overcurrent detector per stage
// R2 - Low threshold: fault flag follows overcurrent
// R3 - High threshold latches shutdown and fault
// R4 - Controller removes PWM drive to acknowledge
// R5 - Shut-down stage leaves PWM pin undriven
// R6 - Each stage has own fault output
// R7 - Fault outputs route to protection inputs by mode
// R8 - Lower thermal threshold warns and attenuates
// R9 - Upper thermal latches shutdown, all faults low
// R10 - Operation inhibited until supplies good
// R11 - Supply drop shuts down, asserts all faults
// R12 - Shared pin is strap input during reset
// R13 - Shared pin reports errors only once running
// R14 - Controller stays off bus while pin low
// R15 - Hysteresis filters switching transients
// R16 - Repeated low overloads step gain down
// R17 - Strap captured once at reset release
`include "afp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module afp_monitor #(
  parameter int unsigned HYST_CYCLES = `AFP_HYST_CYCLES,
  parameter int unsigned GAIN_WINDOW = `AFP_GAIN_WINDOW_CYCLES,
  parameter int unsigned GAIN_EVENTS = `AFP_GAIN_EVENTS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] oc_low,
  input wire logic [3:0] oc_high,
  input wire logic [3:0] pwm_in,
  input wire logic [3:0] pwm_drive_en,
  input wire logic temp_warn,
  input wire logic temp_crit,
  input wire logic supply_ok,
  input wire logic fw_running,
  input wire logic config_strap_lower,
  input wire logic fault_or_strap_pin_in,
  output logic fault_or_strap_pin_out,
  output logic fault_or_strap_pin_oe,
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe,
  output logic [3:0] fault_flag_n,
  output logic [2:0] protect_in,
  output logic [1:0] config_mode,
  output logic thermal_warning,
  output logic [2:0] gain_step,
  output logic supply_inhibit
);
  import afp_pkg::*;

  // Counters are 8 and 16 bits wide; larger settings would wrap silently
  if (HYST_CYCLES < 1 || HYST_CYCLES > 255 || GAIN_WINDOW < 2 || GAIN_WINDOW > 65535 ||
      GAIN_EVENTS < 1 || GAIN_EVENTS > 255) begin : g_bad_param
    $error("afp_monitor: unsupported parameter value");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    afp_state_type state;
    logic strap_taken;
    afp_mode_type mode;
    logic [3:0][7:0] low_cnt;
    logic [3:0][7:0] high_cnt;
    logic [3:0] low_flt;
    logic [3:0] high_flt;
    logic [3:0] oc_latch;
    logic therm_latch;
    logic [3:0] fault_n;
    logic [2:0] prot;
    logic [15:0] win_cnt;
    logic [7:0] ev_cnt;
    logic [2:0] gain;
    logic pin_out;
    logic [3:0] low_seen;
  } afp_regs_type;

  afp_regs_type r_q;
  afp_regs_type r_d;
  logic [3:0] low_rise;
  logic [3:0] fault_raw_n;
  logic [2:0] prot_raw;
  logic global_flt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Hysteresis: must stay asserted or deasserted HYST cycles to flip
  function automatic logic [7:0] hyst_cnt(input logic raw, input logic flt,
                                          input logic [7:0] cnt);
    if (raw == flt) begin
      hyst_cnt = 8'h00;
    end else begin
      hyst_cnt = cnt + 8'h01;
    end
  endfunction : hyst_cnt

  function automatic logic [2:0] route(input afp_mode_type m, input logic [3:0] f);
    unique case (m)
      2'b00, 2'b01: route = {`AFP_PROT_TIE, f[3] & f[2], f[1] & f[0]};
      2'b10: route = {f[3] & f[2], f[1], f[0]};
      2'b11: route = {f[3] & f[2], f[1], f[0]};
    endcase
  endfunction : route

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    low_rise = 4'h0;
    fault_raw_n = 4'hf;
    global_flt = 1'b0;
    prot_raw = 3'h7;
    // Strap sampled at first clock after release, then frozen
    if (!r_q.strap_taken) begin
      r_d.strap_taken = 1'b1; // R17
      r_d.mode = {fault_or_strap_pin_in, config_strap_lower}; // R12
    end
    for (int i = 0; i < 4; i++) begin
      r_d.low_cnt[i] = hyst_cnt(oc_low[i], r_q.low_flt[i], r_q.low_cnt[i]); // R15
      if (r_d.low_cnt[i] >= 8'(HYST_CYCLES)) begin
        r_d.low_flt[i] = oc_low[i];
        r_d.low_cnt[i] = 8'h00;
      end
      r_d.high_cnt[i] = hyst_cnt(oc_high[i], r_q.high_flt[i], r_q.high_cnt[i]); // R15
      if (r_d.high_cnt[i] >= 8'(HYST_CYCLES)) begin
        r_d.high_flt[i] = oc_high[i]; // R1
        r_d.high_cnt[i] = 8'h00;
      end
      // Acknowledge clears, but a fresh trip in the same cycle wins
      if (!pwm_drive_en[i]) begin
        r_d.oc_latch[i] = 1'b0; // R4
      end
      if (r_q.high_flt[i]) begin
        r_d.oc_latch[i] = 1'b1; // R3
      end
      low_rise[i] = r_q.low_flt[i] & ~r_q.low_seen[i];
    end
    r_d.low_seen = r_q.low_flt;
    if (temp_crit) begin
      r_d.therm_latch = 1'b1; // R9
    end
    global_flt = r_q.therm_latch || r_q.state != AFP_RUN; // R9 R10 R11
    for (int i = 0; i < 4; i++) begin
      fault_raw_n[i] = ~(r_q.low_flt[i] | r_q.oc_latch[i] | global_flt); // R2 R3 R6
    end
    r_d.fault_n = fault_raw_n;
    prot_raw = route(r_q.mode, r_q.fault_n); // R7
    r_d.prot = prot_raw;
    unique case (r_q.state)
      AFP_RESET: r_d.state = AFP_WAIT_SUPPLY;
      AFP_WAIT_SUPPLY: if (supply_ok) r_d.state = AFP_RUN; // R10
      AFP_RUN: if (!supply_ok) r_d.state = AFP_WAIT_SUPPLY; // R11
      default: r_d.state = AFP_RESET;
    endcase
    // Gain steps down when enough overload events land in one window
    r_d.win_cnt = r_q.win_cnt + 16'h0001;
    if (|low_rise) begin
      r_d.ev_cnt = r_q.ev_cnt + 8'h01;
    end
    if (r_d.ev_cnt >= 8'(GAIN_EVENTS)) begin
      r_d.ev_cnt = 8'h00;
      r_d.win_cnt = 16'h0000;
      if (r_q.gain < 3'(`AFP_GAIN_STEPS)) begin
        r_d.gain = r_q.gain + 3'h1; // R16
      end
    end else if (r_q.win_cnt >= 16'(GAIN_WINDOW - 1)) begin
      r_d.win_cnt = 16'h0000;
      r_d.ev_cnt = 8'h00;
      if (r_q.gain != 3'h0 && !temp_warn) begin
        r_d.gain = r_q.gain - 3'h1;
      end
    end
    // Any stage fault flag reported only after firmware runs; low also means bus busy
    r_d.pin_out = ~(fw_running & ~(&r_q.fault_n)); // R13 R14
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Faults read clear (4'hf) during reset, then asserted from the first clock until supplies settle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
      r_q.state <= AFP_RESET;
      r_q.mode <= `AFP_MODE_RST;
      r_q.fault_n <= 4'hf;
      r_q.prot <= 3'h7;
      r_q.gain <= `AFP_GAIN_RST;
      r_q.pin_out <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_stage
    // Floating rather than forced, so a shorted load sees no drive
    assign pwm_oe[g] = ~r_q.oc_latch[g] & ~global_flt; // R5
    assign pwm_out[g] = pwm_in[g] & pwm_oe[g];
  end
  assign fault_flag_n = r_q.fault_n;
  assign protect_in = r_q.prot;
  assign config_mode = r_q.mode;
  assign thermal_warning = temp_warn | r_q.therm_latch; // R8
  // Warning forces at least one attenuation step
  assign gain_step = (temp_warn && r_q.gain == 3'h0) ? 3'h1 : r_q.gain; // R8
  assign supply_inhibit = r_q.state != AFP_RUN;
  assign fault_or_strap_pin_oe = r_q.strap_taken & fw_running; // R12 R13
  assign fault_or_strap_pin_out = r_q.pin_out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_latch_holds: assert property (@(posedge clock) disable iff (!rst_b) // R3
    r_q.oc_latch[0] && pwm_drive_en[0] |=> r_q.oc_latch[0])
    else $error("latched overcurrent dropped without acknowledge");
  a_ack_clears: assert property (@(posedge clock) disable iff (!rst_b) // R4
    !pwm_drive_en[0] && !r_q.high_flt[0] |=> !r_q.oc_latch[0])
    else $error("acknowledge did not clear latch");
  a_float_shutdown: assert property (@(posedge clock) disable iff (!rst_b) // R5
    r_q.oc_latch[1] |-> !pwm_oe[1])
    else $error("pwm driven while shut down");
  a_low_pulse: assert property (@(posedge clock) disable iff (!rst_b) // R2
    r_q.low_flt[2] |=> !fault_flag_n[2])
    else $error("low overcurrent not flagged");
  a_thermal_all: assert property (@(posedge clock) disable iff (!rst_b) // R9
    temp_crit |=> ##1 fault_flag_n == 4'h0 && pwm_oe == 4'h0)
    else $error("thermal shutdown incomplete");
  a_supply_drop: assert property (@(posedge clock) disable iff (!rst_b) // R11
    r_q.state == AFP_RUN && !supply_ok |=> ##1 fault_flag_n == 4'h0)
    else $error("supply drop did not assert faults");
  a_supply_wait: assert property (@(posedge clock) disable iff (!rst_b) // R10
    !supply_ok |=> supply_inhibit)
    else $error("operation while supply bad");
  a_strap_stable: assert property (@(posedge clock) disable iff (!rst_b) // R17
    r_q.strap_taken |=> $stable(config_mode))
    else $error("strap changed after capture");
  a_pin_idle: assert property (@(posedge clock) disable iff (!rst_b) // R13
    !fw_running |-> !fault_or_strap_pin_oe)
    else $error("shared pin driven before firmware");
  a_hyst_glitch: assert property (@(posedge clock) disable iff (!rst_b) // R15
    !r_q.low_flt[3] && $rose(oc_low[3]) ##1 !oc_low[3] |=> !r_q.low_flt[3])
    else $error("one-cycle glitch passed hysteresis");
  a_gain_step: assert property (@(posedge clock) disable iff (!rst_b) // R16
    r_d.gain != r_q.gain |-> r_d.gain == r_q.gain + 3'h1 || r_d.gain == r_q.gain - 3'h1)
    else $error("gain changed by more than one step");
  a_high_sets: assert property (@(posedge clock) disable iff (!rst_b) // R3
    r_q.high_flt[1] |=> r_q.oc_latch[1])
    else $error("high overcurrent not latched");
  a_high_flag: assert property (@(posedge clock) disable iff (!rst_b) // R3
    r_q.oc_latch[1] |=> !fault_flag_n[1])
    else $error("latched overcurrent not flagged");
  a_set_wins: assert property (@(posedge clock) disable iff (!rst_b) // R3
    r_q.oc_latch[2] && r_q.high_flt[2] |=> r_q.oc_latch[2])
    else $error("acknowledge beat a standing trip");
  a_float_pin: assert property (@(posedge clock) disable iff (!rst_b) // R5
    r_q.oc_latch[3] |-> !pwm_oe[3] && !pwm_out[3])
    else $error("shut-down stage still driven");
  a_low_release: assert property (@(posedge clock) disable iff (!rst_b) // R2
    !r_q.low_flt[0] && !r_q.oc_latch[0] && !r_q.therm_latch && r_q.state == AFP_RUN
    |=> fault_flag_n[0])
    else $error("fault flag held without a cause");
  a_therm_sticky: assert property (@(posedge clock) disable iff (!rst_b) // R9
    r_q.therm_latch |=> r_q.therm_latch)
    else $error("thermal latch dropped");
  a_therm_float: assert property (@(posedge clock) disable iff (!rst_b) // R9
    r_q.therm_latch |-> pwm_oe == 4'h0)
    else $error("stage driven after thermal trip");
  a_warn_atten: assert property (@(posedge clock) disable iff (!rst_b) // R8
    temp_warn |-> gain_step != 3'h0 && thermal_warning)
    else $error("thermal warning without attenuation");
  a_wait_float: assert property (@(posedge clock) disable iff (!rst_b) // R10
    r_q.state != AFP_RUN |-> pwm_oe == 4'h0 && supply_inhibit)
    else $error("stages driven before supplies good");
  a_supply_good: assert property (@(posedge clock) disable iff (!rst_b) // R10
    r_q.state == AFP_WAIT_SUPPLY && supply_ok |=> !supply_inhibit)
    else $error("run not entered with supplies good");
  a_route_direct: assert property (@(posedge clock) disable iff (!rst_b) // R7
    r_q.mode[1] |=> protect_in[0] == $past(fault_flag_n[0]))
    else $error("direct routing broken");
  a_route_tie: assert property (@(posedge clock) disable iff (!rst_b) // R7
    !r_q.mode[1] |=> protect_in[2])
    else $error("unused protection input not tied high");
  a_pin_fault: assert property (@(posedge clock) disable iff (!rst_b) // R13
    fw_running && fault_flag_n != 4'hf |=> !fault_or_strap_pin_out)
    else $error("shared pin missed a fault");
  a_pin_quiet: assert property (@(posedge clock) disable iff (!rst_b) // R13
    !fw_running |=> fault_or_strap_pin_out)
    else $error("shared pin low before firmware");
  a_strap_input: assert property (@(posedge clock) disable iff (!rst_b) // R12
    !r_q.strap_taken |-> !fault_or_strap_pin_oe)
    else $error("shared pin driven during strap sampling");
  a_gain_hold: assert property (@(posedge clock) disable iff (!rst_b) // R16
    !(|low_rise) && r_q.win_cnt < 16'(GAIN_WINDOW - 1) |=> r_q.gain == $past(r_q.gain))
    else $error("gain moved without cause");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_high_trip: cover property (@(posedge clock) disable iff (!rst_b) $rose(r_q.oc_latch[0]));
  c_pin_low: cover property (@(posedge clock) disable iff (!rst_b) $fell(fault_or_strap_pin_out));
  c_direct_mode: cover property (@(posedge clock) disable iff (!rst_b) config_mode[1] && protect_in != 3'h7);
  c_thermal: cover property (@(posedge clock) disable iff (!rst_b) $rose(r_q.therm_latch));
  c_gain_down: cover property (@(posedge clock) disable iff (!rst_b) r_q.gain == 3'h2);
endmodule : afp_monitor
`default_nettype wire

// ---- test/afp_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----
// Controller and strap resistor
// ----
module afp_ctrl_model (
  input wire logic clock,
  input wire logic dev_level,
  input wire logic dev_drive,
  input wire logic strap_up,
  input wire logic ack_en,
  input wire logic [3:0] stage_oe,
  output logic pin_level,
  output logic bus_off,
  output logic [3:0] drive_en
);
  // Pull resistor shows only while undriven
  assign pin_level = dev_drive ? dev_level : strap_up;
  // Low level: device owns the bus, keep off
  assign bus_off = ~pin_level;
  initial drive_en = 4'hF;
  // Ack drops drive only on stages that float
  always @(posedge clock) begin
    drive_en <= ack_en ? stage_oe : 4'hF;
  end
endmodule : afp_ctrl_model
`default_nettype wire

// ---- test/tb_amp_fault_protection_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_amp_fault_protection_monitor;
  import afp_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] oc_low = 4'h0, oc_high = 4'h0, pwm_in = 4'h0;
  logic temp_warn = 1'b0, temp_crit = 1'b0, supply_ok = 1'b1;
  logic fw_running = 1'b0, strap_lo = 1'b0, strap_up = 1'b0, ack_en = 1'b0;
  logic pin_i, pin_o, pin_oe, bus_off, warn, inh;
  logic [3:0] drv, pwm_out, pwm_oe, flt_n;
  logic [2:0] prot, gain;
  logic [1:0] mode;
  int errors = 0;
  int checked = 0;
  always #4 clock = ~clock;
  // ----
  // Short counts keep the run brief
  // ----
  afp_monitor #(.HYST_CYCLES(2), .GAIN_WINDOW(16), .GAIN_EVENTS(2)) dut_u (
    .clock, .rst_b, .oc_low, .oc_high, .pwm_in, .pwm_drive_en(drv),
    .temp_warn, .temp_crit, .supply_ok, .fw_running,
    .config_strap_lower(strap_lo), .fault_or_strap_pin_in(pin_i),
    .fault_or_strap_pin_out(pin_o), .fault_or_strap_pin_oe(pin_oe),
    .pwm_out, .pwm_oe, .fault_flag_n(flt_n), .protect_in(prot),
    .config_mode(mode), .thermal_warning(warn), .gain_step(gain),
    .supply_inhibit(inh)
  );
  afp_ctrl_model ctrl_u (
    .clock, .dev_level(pin_o), .dev_drive(pin_oe), .strap_up, .ack_en,
    .stage_oe(pwm_oe), .pin_level(pin_i), .bus_off, .drive_en(drv)
  );
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : tick
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  function automatic logic [2:0] pexp(input logic [1:0] m, input logic [3:0] f);
    return m[1] ? {f[2] & f[3], f[1], f[0]} : {1'b1, f[2] & f[3], f[0] & f[1]};
  endfunction : pexp
  // Strap flipped after capture must not move the mode
  task automatic boot(input logic [1:0] m);
    rst_b <= 1'b0;
    strap_up <= m[1];
    strap_lo <= m[0];
    tick(6);
    chk(flt_n === 4'hF && inh === 1'b1 && pwm_oe === 4'h0, "reset");
    rst_b <= 1'b1;
    tick(2);
    strap_up <= ~m[1];
    tick(8);
    chk(mode === m, "mode");
  endtask : boot
  initial begin
    int k;
    int i;
    logic [3:0] r;
    void'($urandom(19162));
    pwm_in <= 4'($urandom);
    boot(2'h0);
    supply_ok <= 1'b0;
    tick(6);
    chk(inh === 1'b1 && flt_n === 4'h0 && pwm_oe === 4'h0, "brownout");
    supply_ok <= 1'b1;
    tick(8);
    chk(inh === 1'b0 && flt_n === 4'hF, "recover");
    $display("supply test done");
    k = $urandom_range(3, 0);
    oc_low[k] <= 1'b1;
    tick(1);
    oc_low[k] <= 1'b0;
    repeat (5) begin
      tick(1);
      chk(flt_n === 4'hF, "glitch");
    end
    oc_low[k] <= 1'b1;
    tick(6);
    chk(flt_n === ~(4'h1 << k), "low fault");
    oc_low[k] <= 1'b0;
    tick(6);
    chk(flt_n === 4'hF, "low end");
    k = $urandom_range(3, 0);
    oc_high[k] <= 1'b1;
    tick(6);
    chk(flt_n === ~(4'h1 << k) && pwm_oe[k] === 1'b0, "high");
    oc_high[k] <= 1'b0;
    tick(6);
    chk(flt_n[k] === 1'b0 && pwm_oe[k] === 1'b0, "latch");
    ack_en <= 1'b1;
    for (i = 0; i < 30 && flt_n[k] !== 1'b1; i++) tick(1);
    if (i == 30) begin
      chk(1'b0, "ack hang");
      conclude();
    end
    ack_en <= 1'b0;
    tick(4);
    chk(flt_n === 4'hF && pwm_oe === 4'hF && pwm_out === pwm_in, "acked");
    $display("overcurrent test done");
    repeat (4) begin
      oc_low[0] <= 1'b1;
      tick(3);
      oc_low[0] <= 1'b0;
      tick(3);
    end
    chk(gain >= 3'h1 && gain <= 3'h2, "gain");
    temp_warn <= 1'b1;
    tick(3);
    chk(warn === 1'b1 && gain >= 3'h1 && pwm_oe === 4'hF, "warn");
    temp_warn <= 1'b0;
    oc_low[1] <= 1'b1;
    tick(6);
    chk(pin_oe === 1'b0, "early pin");
    fw_running <= 1'b1;
    tick(3);
    chk(pin_oe === 1'b1 && pin_i === 1'b0 && bus_off === 1'b1, "pin low");
    oc_low[1] <= 1'b0;
    tick(6);
    chk(pin_oe === 1'b1 && pin_i === 1'b1, "pin high");
    fw_running <= 1'b0;
    temp_crit <= 1'b1;
    tick(3);
    temp_crit <= 1'b0;
    tick(6);
    chk(flt_n === 4'h0 && pwm_oe === 4'h0 && pwm_out === 4'h0 && warn === 1'b1, "crit");
    $display("thermal test done");
    for (int m = 0; m < 4; m++) begin
      boot(2'(m));
      r = 4'($urandom);
      oc_low <= r;
      tick(6);
      chk(prot === pexp(2'(m), ~r), "routing");
      oc_low <= 4'h0;
      tick(6);
    end
    $display("mode test done");
    conclude();
  end
endmodule : tb_amp_fault_protection_monitor
`default_nettype wire
